// >>> src/eq_bank_switch_control.v
/*
 * equalizer bank-switch command word, coefficient write steering, bus
 * address strap capture and active-low fault flag on the shared pin.
 * assumes a serial control bus decoder on i_core_clk delivering register
 * and coefficient accesses, a rate detector on the same clock, and fault
 * levels from analog monitors that are asynchronous to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "eq_bank_switch_control_map.vh"

// How it works
// - bit seven high bypasses biquad stages zero-seven
// - bit five selects programmed or default bank mapping
// - bit four mirrors left biquad writes to right
// - bank code zero writes straight to processor
// - codes one-three pick bank, four automatic
// - default map: 32k bank1, 44/48k bank2, else bank3
// - shared pin is an input during power-up
// - strap high gives 0x36, low gives 0x34
// - address latched once, pin then becomes fault output
// - pin low from fault until status cleared
// - overcurrent, overtemperature, overvoltage, undervoltage drive fault
// - map bytes hold one bit per rate group
module eq_bank_switch_control #(
  parameter DATA_W = 32,
  parameter [7:0] STRAP_SETTLE = 8'h10
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_clk_en,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  output reg [31:0] o_reg_rdata,
  input wire i_coef_wr,
  input wire [7:0] i_coef_addr,
  input wire [DATA_W-1:0] i_coef_data,
  output reg o_coef_wr,
  output reg [7:0] o_coef_addr,
  output reg [DATA_W-1:0] o_coef_data,
  output reg [1:0] o_coef_bank,
  output reg o_gang_wr,
  output reg [7:0] o_gang_addr,
  input wire [2:0] i_rate_group,
  output reg [1:0] o_play_bank,
  output reg o_eq_bypass,
  input wire i_fault_oc,
  input wire i_fault_ot,
  input wire i_fault_ov,
  input wire i_fault_uv,
  input wire i_adr_fault_in,
  output reg o_adr_fault_out,
  output reg o_adr_fault_oe,
  output reg [6:0] o_bus_addr,
  output reg o_addr_valid
);

  // power-up phases, one-hot
  localparam [1:0] ST_STRAP = 2'b01;
  localparam [1:0] ST_FAULT = 2'b10;

  reg [31:0] eq_bank_control; // command word
  reg [3:0] err_status; // sticky fault causes
  reg [1:0] state; // strap or fault phase
  reg [7:0] settle_cnt; // strap settle counter
  reg [1:0] pin_sync; // strap pin synchroniser
  reg [3:0] fault_meta; // fault first stage
  reg [3:0] fault_sync; // fault second stage
  reg [1:0] next_play_bank; // bank chosen for current rate
  reg [1:0] next_coef_bank; // bank for coefficient writes
  reg next_gang_hit; // write lands in a left window
  reg [7:0] next_gang_addr; // matching right location
  wire [3:0] fault_now; // live synchronised causes
  wire [2:0] bank_code; // bank field

  assign fault_now = fault_sync;
  assign bank_code = eq_bank_control[`BANK_FIELD_HI:`BANK_FIELD_LO];

  // position of a rate group inside a map byte
  function [2:0] map_bit;
    input [2:0] rate;
    begin
      case (rate)
        `RATE_8K: map_bit = `MAPBIT_8K;
        `RATE_11K: map_bit = `MAPBIT_11K;
        `RATE_16K: map_bit = `MAPBIT_16K;
        `RATE_22K: map_bit = `MAPBIT_22K;
        `RATE_32K: map_bit = `MAPBIT_32K;
        default: map_bit = `MAPBIT_48K;
      endcase
    end
  endfunction

  // pick the bank serving the current rate
  always @* begin
    next_play_bank = `BANK_3;
    if (eq_bank_control[`MAP_EN_BIT]) begin
      // programmed map, bank one has priority over two, two over three
      if (eq_bank_control[`BANK1_MAP_LO + map_bit(i_rate_group)]) begin
        next_play_bank = `BANK_1;
      end else if (eq_bank_control[`BANK2_MAP_LO + map_bit(i_rate_group)]) begin
        next_play_bank = `BANK_2;
      end else begin
        next_play_bank = `BANK_3;
      end
    end else begin
      // default map
      if (i_rate_group == `RATE_32K) begin
        next_play_bank = `BANK_1;
      end else if (i_rate_group >= `RATE_48K) begin // top codes all mean 44.1/48k
        next_play_bank = `BANK_2;
      end else begin
        next_play_bank = `BANK_3;
      end
    end
  end

  // where coefficient writes go
  always @* begin
    case (bank_code)
      `BANK_CODE_DIRECT: next_coef_bank = `BANK_DIRECT;
      `BANK_CODE_B1: next_coef_bank = `BANK_1;
      `BANK_CODE_B2: next_coef_bank = `BANK_2;
      `BANK_CODE_B3: next_coef_bank = `BANK_3;
      `BANK_CODE_AUTO: next_coef_bank = next_play_bank;
      default: next_coef_bank = `BANK_DIRECT; // reserved codes go direct
    endcase
  end

  // left-to-right mirror address
  always @* begin
    next_gang_hit = 1'b0;
    next_gang_addr = 8'h00;
    if (i_coef_addr >= `GANG_A_LO && i_coef_addr <= `GANG_A_HI) begin
      next_gang_hit = 1'b1;
      next_gang_addr = i_coef_addr + `GANG_A_OFS;
    end else if (i_coef_addr >= `GANG_B_LO && i_coef_addr <= `GANG_B_HI) begin
      next_gang_hit = 1'b1;
      next_gang_addr = i_coef_addr + `GANG_B_OFS;
    end
  end

  // synchronisers for the pin and the fault monitors
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_sync <= 2'b00;
      fault_meta <= 4'h0;
      fault_sync <= 4'h0;
    end else if (i_clk_en) begin
      pin_sync <= {pin_sync[0], i_adr_fault_in};
      fault_meta <= {i_fault_uv, i_fault_ov, i_fault_ot, i_fault_oc};
      fault_sync <= fault_meta;
    end
  end

  // command word and register reads
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      eq_bank_control <= `EQ_BANK_CONTROL_RESET;
      o_reg_rdata <= 32'h00000000;
    end else if (i_clk_en) begin
      if (i_reg_wr && i_reg_addr == `EQ_BANK_CONTROL_ADDR) begin
        // reserved bits six and three held at zero
        eq_bank_control <= i_reg_wdata & `EQ_BANK_CONTROL_WMASK;
      end
      if (i_reg_rd) begin
        case (i_reg_addr)
          `EQ_BANK_CONTROL_ADDR: o_reg_rdata <= eq_bank_control;
          `ERR_STATUS_ADDR: o_reg_rdata <= {28'h0000000, err_status};
          default: o_reg_rdata <= 32'h00000000; // unmapped reads zero
        endcase
      end
    end
  end

  // sticky fault causes, a new fault wins over a clear
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      err_status <= 4'h0;
    end else if (i_clk_en) begin
      if (i_reg_wr && i_reg_addr == `ERR_STATUS_ADDR) begin
        // written zeros clear, live causes stay set
        err_status <= (err_status & i_reg_wdata[3:0]) | fault_now;
      end else begin
        err_status <= err_status | fault_now;
      end
    end
  end

  // strap capture, then fault flag on the shared pin
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= ST_STRAP;
      settle_cnt <= 8'h00;
      o_bus_addr <= `ADDR_STRAP_LOW;
      o_addr_valid <= 1'b0;
      o_adr_fault_out <= 1'b0;
      o_adr_fault_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_adr_fault_out <= 1'b0; // open drain, only ever pulls low
      case (state)
        ST_STRAP: begin
          o_adr_fault_oe <= 1'b0; // pin is an input while strapping
          if (settle_cnt == STRAP_SETTLE) begin
            // latch address once
            o_bus_addr <= pin_sync[1] ? `ADDR_STRAP_HIGH : `ADDR_STRAP_LOW;
            o_addr_valid <= 1'b1;
            state <= ST_FAULT;
          end else begin
            settle_cnt <= settle_cnt + 8'h01;
          end
        end
        ST_FAULT: begin
          // pull low on a live cause or any sticky bit
          o_adr_fault_oe <= (|err_status) | (|fault_now);
        end
        default: begin
          state <= ST_STRAP;
          o_adr_fault_oe <= 1'b0;
        end
      endcase
    end
  end

  // steered coefficient writes and processor controls
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_coef_wr <= 1'b0;
      o_coef_addr <= 8'h00;
      o_coef_data <= {DATA_W{1'b0}};
      o_coef_bank <= `BANK_DIRECT;
      o_gang_wr <= 1'b0;
      o_gang_addr <= 8'h00;
      o_play_bank <= `BANK_3;
      o_eq_bypass <= 1'b0;
    end else if (i_clk_en) begin
      o_coef_wr <= i_coef_wr;
      o_gang_wr <= i_coef_wr & next_gang_hit & eq_bank_control[`GANG_BIT];
      if (i_coef_wr) begin
        o_coef_addr <= i_coef_addr;
        o_coef_data <= i_coef_data;
        o_coef_bank <= next_coef_bank;
        o_gang_addr <= next_gang_addr;
      end
      // play bank direct unless the bank code is automatic
      o_play_bank <= (bank_code == `BANK_CODE_AUTO) ? next_play_bank : `BANK_DIRECT;
      o_eq_bypass <= eq_bank_control[`EQ_OFF_BIT];
    end
  end

endmodule // eq_bank_switch_control
`default_nettype wire

// >>> src/eq_bank_switch_control_map.vh
/*
 * register offsets, field positions, reset values and encodings for the
 * equalizer bank-switch control block.
 * assumes it is included by its bare name from the design file.
 */
`ifndef EQ_BANK_SWITCH_CONTROL_MAP_VH
`define EQ_BANK_SWITCH_CONTROL_MAP_VH

// register offsets on the serial control bus
`define ERR_STATUS_ADDR 8'h02
`define EQ_BANK_CONTROL_ADDR 8'h50

// command word reset value and field positions
`define EQ_BANK_CONTROL_RESET 32'h0f108000
`define EQ_BANK_CONTROL_WMASK 32'hffffffb7
`define EQ_OFF_BIT 7
`define MAP_EN_BIT 5
`define GANG_BIT 4
`define BANK_FIELD_HI 2
`define BANK_FIELD_LO 0
`define BANK1_MAP_LO 8
`define BANK2_MAP_LO 16
`define BANK3_MAP_LO 24

// bank field codes
`define BANK_CODE_DIRECT 3'h0
`define BANK_CODE_B1 3'h1
`define BANK_CODE_B2 3'h2
`define BANK_CODE_B3 3'h3
`define BANK_CODE_AUTO 3'h4

// bank numbers on the outputs, zero meaning direct to the audio processor
`define BANK_DIRECT 2'h0
`define BANK_1 2'h1
`define BANK_2 2'h2
`define BANK_3 2'h3

// sample-rate group codes from the rate detector
`define RATE_8K 3'h0
`define RATE_11K 3'h1
`define RATE_16K 3'h2
`define RATE_22K 3'h3
`define RATE_32K 3'h4
`define RATE_48K 3'h5

// bit of each rate group inside one bank-map byte
`define MAPBIT_8K 3'h1
`define MAPBIT_11K 3'h0
`define MAPBIT_16K 3'h3
`define MAPBIT_22K 3'h2
`define MAPBIT_32K 3'h7
`define MAPBIT_48K 3'h4

// left biquad windows and their right-channel distance
`define GANG_A_LO 8'h29
`define GANG_A_HI 8'h2f
`define GANG_A_OFS 8'h07
`define GANG_B_LO 8'h58
`define GANG_B_HI 8'h5b
`define GANG_B_OFS 8'h04

// error status bit positions
`define ERR_OC_BIT 0
`define ERR_OT_BIT 1
`define ERR_OV_BIT 2
`define ERR_UV_BIT 3

// bus address choices from the strap
`define ADDR_STRAP_HIGH 7'h1b
`define ADDR_STRAP_LOW 7'h1a

`endif

// >>> verif/eq_bank_switch_control_asserts.sv
/* port checker for the bank-switch control block.
   assumes it is bound onto the design top, one clock, reset high. */
`timescale 1ns/1ps
`default_nettype none
module eq_bank_switch_control_asserts #(parameter [7:0] STRAP_SETTLE = 8'h10) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_clk_en,
  input wire i_reg_wr,
  input wire [7:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire i_coef_wr,
  input wire [7:0] i_coef_addr,
  input wire o_coef_wr,
  input wire [7:0] o_coef_addr,
  input wire o_gang_wr,
  input wire [7:0] o_gang_addr,
  input wire o_eq_bypass,
  input wire i_fault_oc,
  input wire i_fault_ot,
  input wire i_fault_ov,
  input wire i_fault_uv,
  input wire i_adr_fault_in,
  input wire o_adr_fault_oe,
  input wire [6:0] o_bus_addr,
  input wire o_addr_valid
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  wire any_flt = i_fault_oc | i_fault_ot | i_fault_ov | i_fault_uv; // any fault cause
  wire clr = i_clk_en && i_reg_wr && i_reg_addr == 8'h02; // status write taken
  wire cmd = i_clk_en && i_reg_wr && i_reg_addr == 8'h50; // command write taken
  wire byp = i_reg_wdata[7]; // bypass bit of the write
  chk_coef_echo: assert property (i_coef_wr |=> o_coef_wr && o_coef_addr == $past(i_coef_addr))
    else $error("coef write not echoed");
  chk_gang_addr: assert property (o_gang_wr |-> o_gang_addr == o_coef_addr + (o_coef_addr < 8'h58 ? 8'h07 : 8'h04))
    else $error("mirror address wrong");
  chk_gang_window: assert property (o_gang_wr |-> o_coef_wr && o_coef_addr inside {[8'h29:8'h2f], [8'h58:8'h5b]})
    else $error("mirror outside left window");
  chk_bypass_bit: assert property (cmd |=> ##1 o_eq_bypass == $past(byp, 2))
    else $error("bypass not from bit seven");
  chk_strap_addr: assert property ($rose(o_addr_valid) |-> o_bus_addr == {6'h0d, i_adr_fault_in})
    else $error("strap address wrong");
  chk_addr_kept: assert property (o_addr_valid |=> o_addr_valid && $stable(o_bus_addr))
    else $error("latched address moved");
  chk_pin_input: assert property (!o_addr_valid |-> !o_adr_fault_oe)
    else $error("pin driven during strap");
  chk_fault_raise: assert property ((o_addr_valid && any_flt) [*3] |=> o_adr_fault_oe)
    else $error("fault not flagged");
  chk_fault_hold: assert property ($fell(o_adr_fault_oe) |-> $past(clr, 2))
    else $error("flag dropped without clear");
  cover property (o_gang_wr);
  cover property ($rose(o_adr_fault_oe));
  cover property ($rose(o_addr_valid));
endmodule // eq_bank_switch_control_asserts
bind eq_bank_switch_control eq_bank_switch_control_asserts #(.STRAP_SETTLE(STRAP_SETTLE)) u_chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_clk_en(i_clk_en), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_coef_wr(i_coef_wr), .i_coef_addr(i_coef_addr), .o_coef_wr(o_coef_wr),
  .o_coef_addr(o_coef_addr), .o_gang_wr(o_gang_wr), .o_gang_addr(o_gang_addr), .o_eq_bypass(o_eq_bypass),
  .i_fault_oc(i_fault_oc), .i_fault_ot(i_fault_ot), .i_fault_ov(i_fault_ov), .i_fault_uv(i_fault_uv),
  .i_adr_fault_in(i_adr_fault_in), .o_adr_fault_oe(o_adr_fault_oe), .o_bus_addr(o_bus_addr),
  .o_addr_valid(o_addr_valid));
`default_nettype wire

// >>> verif/strap_pin_model.sv
/* board side of the shared address and fault pin.
   assumes the device only ever pulls the pin low. */
`timescale 1ns/1ps
`default_nettype none
module strap_pin_model (
  input wire i_strap_high,
  input wire i_drive_en,
  input wire i_drive_val,
  output wire o_pin
);
  // strap resistor sets the level unless the device pulls it
  assign o_pin = i_drive_en ? i_drive_val : i_strap_high;
endmodule // strap_pin_model
`default_nettype wire

// >>> verif/eq_bank_switch_control_tb.sv
/* self-checking bench for the bank-switch control block.
   assumes the map header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "eq_bank_switch_control_map.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module eq_bank_switch_control_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, cwr = 0, strap = 1, en = 1;
  logic [7:0] adr = 0, cadr = 0;
  logic [31:0] wd = 0, cd = 0, rdat;
  logic [2:0] rate = 0;
  logic [3:0] flt = 0;
  logic [15:0] seed = 16'hce59;
  int bad_count = 0, total_checks = 0, cyc = 0;
  wire [31:0] o_rdata, o_cdata;
  wire [7:0] o_cadr, o_gadr;
  wire [6:0] o_badr;
  wire [1:0] o_bank, o_pbank;
  wire o_cwr, o_gwr, o_byp, o_out, o_oe, o_valid, pin;
  eq_bank_switch_control #(.STRAP_SETTLE(8'h02)) dut (.i_core_clk(clk), .i_reset(rst), .i_clk_en(en),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(adr), .i_reg_wdata(wd), .o_reg_rdata(o_rdata), .i_coef_wr(cwr),
    .i_coef_addr(cadr), .i_coef_data(cd), .o_coef_wr(o_cwr), .o_coef_addr(o_cadr), .o_coef_data(o_cdata),
    .o_coef_bank(o_bank), .o_gang_wr(o_gwr), .o_gang_addr(o_gadr), .i_rate_group(rate), .o_play_bank(o_pbank),
    .o_eq_bypass(o_byp), .i_fault_oc(flt[0]), .i_fault_ot(flt[1]), .i_fault_ov(flt[2]), .i_fault_uv(flt[3]),
    .i_adr_fault_in(pin), .o_adr_fault_out(o_out), .o_adr_fault_oe(o_oe), .o_bus_addr(o_badr),
    .o_addr_valid(o_valid));
  strap_pin_model host_pin (.i_strap_high(strap), .i_drive_en(o_oe), .i_drive_val(o_out), .o_pin(pin));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
  task conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // two lfsr steps make one word
  task rnd(output logic [31:0] r);
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    r[15:0] = seed;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    r[31:16] = seed;
  endtask
  // bank a coefficient write should land in
  function automatic logic [1:0] exp_bank(input logic [31:0] w, input logic [2:0] r);
    logic [2:0] b;
    b = (r == 0) ? 3'h1 : (r == 1) ? 3'h0 : (r == 2) ? 3'h3 : (r == 3) ? 3'h2 : (r == 4) ? 3'h7 : 3'h4;
    if (w[2:0] != 3'h4) exp_bank = w[2] ? 2'h0 : w[1:0];
    else if (!w[5]) exp_bank = (r == 4) ? 2'h1 : (r >= 5) ? 2'h2 : 2'h3;
    else exp_bank = w[8 + b] ? 2'h1 : w[16 + b] ? 2'h2 : 2'h3;
  endfunction
  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = 1;
    adr = a;
    wd = d;
    @(negedge clk);
    wr = 0;
  endtask
  task reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    rd = 1;
    adr = a;
    @(negedge clk);
    rd = 0;
    @(negedge clk);
    d = o_rdata;
  endtask
  // one coefficient write, checked against word w
  task coef(input logic [7:0] a, input logic [31:0] w);
    logic g;
    g = w[4] && (a inside {[8'h29:8'h2f], [8'h58:8'h5b]});
    rnd(cd);
    @(negedge clk);
    cwr = 1;
    cadr = a;
    @(negedge clk);
    cwr = 0;
    `CHK("coef_wr", 1'b1, o_cwr)
    `CHK("coef_addr", a, o_cadr)
    `CHK("coef_data", cd, o_cdata)
    `CHK("gang_wr", g, o_gwr)
    if (g) `CHK("gang_addr", a + (a < 8'h58 ? 8'h07 : 8'h04), o_gadr)
    `CHK("coef_bank", exp_bank(w, rate), o_bank)
    `CHK("play_bank", w[2:0] == 3'h4 ? exp_bank(w, rate) : 2'h0, o_pbank)
  endtask
  initial begin
    logic [31:0] w;
    logic [7:0] edges [8] = '{8'h28, 8'h29, 8'h2f, 8'h30, 8'h57, 8'h58, 8'h5b, 8'h5c};
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 0;
    reg_rd(8'h50, rdat);
    `CHK("reset_word", `EQ_BANK_CONTROL_RESET, rdat)
    reg_rd(8'h10, rdat);
    `CHK("unmapped", 32'h0, rdat)
    for (int i = 0; i < 50 && o_valid !== 1'b1; i++) @(negedge clk);
    `CHK("addr_high", `ADDR_STRAP_HIGH, o_badr)
    repeat (8) begin
      rnd(w);
      w[6] = 1'b0;
      w[3] = 1'b0;
      if (w[2]) w[1:0] = 2'b00;
      reg_wr(8'h50, w);
      reg_rd(8'h50, rdat);
      `CHK("word", w & `EQ_BANK_CONTROL_WMASK, rdat)
      `CHK("eq_bypass", w[7], o_byp)
      rate = seed[2:0];
      coef(w[31:24], w);
    end
    $display("test words done");
    en = 0;
    reg_wr(8'h50, w ^ 32'h000000b0);
    en = 1;
    reg_rd(8'h50, rdat);
    `CHK("frozen", w & `EQ_BANK_CONTROL_WMASK, rdat)
    `CHK("frozen_bypass", w[7], o_byp)
    for (int c = 0; c < 16; c++) begin
      rnd(w);
      w[7:0] = {2'b00, c[3], 2'b10, 3'(c % 5)};
      reg_wr(8'h50, w);
      for (int r = 0; r < 8; r++) begin
        rate = r[2:0];
        coef(edges[r], w);
      end
    end
    $display("test banks done");
    for (int k = 0; k < 4; k++) begin
      flt[k] = 1;
      repeat (5) @(negedge clk);
      `CHK("pin_low", 1'b0, pin)
      flt[k] = 0;
      repeat (5) @(negedge clk);
      reg_rd(8'h02, rdat);
      `CHK("status", 32'h1 << k, rdat)
      `CHK("held", 1'b1, o_oe)
      reg_wr(8'h02, 32'h0);
      repeat (3) @(negedge clk);
      `CHK("released", 1'b0, o_oe)
    end
    $display("test faults done");
    strap = 0;
    flt = 4'h1;
    rst = 1;
    @(negedge clk);
    rst = 0;
    for (int i = 0; i < 50 && o_valid !== 1'b1; i++) @(negedge clk);
    `CHK("addr_low", `ADDR_STRAP_LOW, o_badr)
    `CHK("valid", 1'b1, o_valid)
    repeat (4) @(negedge clk);
    `CHK("late_flag", 1'b0, pin)
    $display("test strap done");
    conclude();
  end
endmodule // eq_bank_switch_control_tb
`default_nettype wire
